// ---- pcsr_params.svh ----
`ifndef PCSR_PARAMS_SVH
`define PCSR_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PCSR_STATUS_OFFSET 8'h06
`define PCSR_STATUS_RESET 16'h0210

// ****************************************************************
// Field positions
// ****************************************************************
`define PCSR_BIT_PARITY 15
`define PCSR_BIT_SYSERR 14
`define PCSR_BIT_MST_ABORT 13
`define PCSR_BIT_TABT_RX 12
`define PCSR_BIT_TABT_TX 11
`define PCSR_DEVSEL_HI 10
`define PCSR_DEVSEL_LO 9
`define PCSR_BIT_DPAR 8
`define PCSR_BIT_B2B 7
`define PCSR_BIT_USER_FEAT 6
`define PCSR_BIT_FAST 5
`define PCSR_BIT_CAP_LIST 4
`define PCSR_BIT_INTSTAT 3

// ****************************************************************
// Hardwired field values
// ****************************************************************
`define PCSR_DEVSEL_MEDIUM 2'h1
`define PCSR_B2B_VAL 1'h0
`define PCSR_USER_FEAT_VAL 1'h0
`define PCSR_FAST_VAL 1'h0
`define PCSR_CAP_LIST_VAL 1'h1
`define PCSR_RSVD_VAL 3'h0

`endif

// ---- pcsr_pkg.sv ----
package pcsr_pkg;

  // Single-cycle event pulses from the bus engine, same clock
  typedef struct packed {
    logic addr_parity_err;
    logic data_parity_err;
    logic perr_seen;
    logic was_master;
    logic master_abort;
    logic target_abort_rcvd;
    logic target_abort_sent;
  } pcsr_evt_s;

  // Enable bits held in the command register of this function
  typedef struct packed {
    logic int_disable;
    logic system_error_enable;
    logic parity_response_enable;
  } pcsr_cmd_s;

endpackage : pcsr_pkg

// ---- pcsr_status.sv ----
`timescale 1ns/1ps
`include "pcsr_params.svh"
module pcsr_status (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  input wire pcsr_pkg::pcsr_evt_s bus_evt,
  input wire pcsr_pkg::pcsr_cmd_s cmd,
  input wire logic int_condition,
  input wire logic serr_done,
  output logic [15:0] cfg_rdata_q,
  output logic serr_req_q,
  output logic int_n_q
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Set wins over clear so an event in the clearing cycle survives
  function automatic logic pcsr_sticky(input logic cur, input logic set,
                                       input logic clr);
    pcsr_sticky = set | (cur & ~clr);
  endfunction : pcsr_sticky

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic detected_parity_flag_q;
  logic signaled_system_error_flag_q;
  logic master_abort_received_flag_q;
  logic target_abort_received_flag_q;
  logic target_abort_signaled_flag_q;
  logic master_data_parity_flag_q;
  logic int_stat_q;

  wire hit = cfg_addr == `PCSR_STATUS_OFFSET;
  wire wr_hi = cfg_wr & hit & cfg_be[1];
  // Only the high byte holds clearable bits; low byte writes do nothing
  wire [15:0] clr = wr_hi ? {cfg_wdata[15:8], 8'h00} : 16'h0000;

  wire set_par = bus_evt.addr_parity_err | bus_evt.data_parity_err;
  // Address parity reaches SERR only with both enables on
  wire serr_d = bus_evt.addr_parity_err & cmd.system_error_enable
    & cmd.parity_response_enable;
  wire set_serr = serr_req_q & cmd.system_error_enable;
  wire set_dpar = bus_evt.perr_seen & bus_evt.was_master
    & cmd.parity_response_enable;
  wire int_n_d = ~(int_condition & ~cmd.int_disable);

  wire [15:0] status_word = {
    detected_parity_flag_q,
    signaled_system_error_flag_q,
    master_abort_received_flag_q,
    target_abort_received_flag_q,
    target_abort_signaled_flag_q,
    `PCSR_DEVSEL_MEDIUM,
    master_data_parity_flag_q,
    `PCSR_B2B_VAL, `PCSR_USER_FEAT_VAL, `PCSR_FAST_VAL,
    `PCSR_CAP_LIST_VAL,
    int_stat_q,
    `PCSR_RSVD_VAL
  };

  wire [15:0] rdata_d = hit ? status_word : 16'h0000;

  // ****************************************************************
  // Sticky error flags
  // ****************************************************************
  // Only the asynchronous global reset touches these flags
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      detected_parity_flag_q <= 1'b0;
      signaled_system_error_flag_q <= 1'b0;
      master_abort_received_flag_q <= 1'b0;
      target_abort_received_flag_q <= 1'b0;
      target_abort_signaled_flag_q <= 1'b0;
      master_data_parity_flag_q <= 1'b0;
    end
    else
    begin
      detected_parity_flag_q <= pcsr_sticky(detected_parity_flag_q,
        set_par, clr[`PCSR_BIT_PARITY]);
      signaled_system_error_flag_q <= pcsr_sticky(
        signaled_system_error_flag_q, set_serr,
        clr[`PCSR_BIT_SYSERR]);
      master_abort_received_flag_q <= pcsr_sticky(
        master_abort_received_flag_q, bus_evt.master_abort,
        clr[`PCSR_BIT_MST_ABORT]);
      target_abort_received_flag_q <= pcsr_sticky(
        target_abort_received_flag_q, bus_evt.target_abort_rcvd,
        clr[`PCSR_BIT_TABT_RX]);
      target_abort_signaled_flag_q <= pcsr_sticky(
        target_abort_signaled_flag_q, bus_evt.target_abort_sent,
        clr[`PCSR_BIT_TABT_TX]);
      master_data_parity_flag_q <= pcsr_sticky(master_data_parity_flag_q,
        set_dpar, clr[`PCSR_BIT_DPAR]);
    end
  end

  // ****************************************************************
  // Live status, outputs and read port
  // ****************************************************************
  // SERR request holds until the bus engine reports it driven
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_stat_q <= 1'b0;
      int_n_q <= 1'b1;
      serr_req_q <= 1'b0;
      cfg_rdata_q <= 16'h0000;
    end
    else
    begin
      int_stat_q <= int_condition;
      int_n_q <= int_n_d;
      serr_req_q <= serr_d | (serr_req_q & ~serr_done);
      if (cfg_rd)
        cfg_rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_W1C_CLEARS: assert property (
    wr_hi && cfg_wdata[13] && !bus_evt.master_abort
    |=> !master_abort_received_flag_q)
    else $error("write one did not clear master abort flag");

  AST_ZERO_KEEPS: assert property (
    wr_hi && !cfg_wdata[12] && target_abort_received_flag_q
    |=> target_abort_received_flag_q)
    else $error("write zero changed target abort flag");

  AST_PARITY_SET: assert property (
    bus_evt.data_parity_err && !cmd.parity_response_enable
    |=> detected_parity_flag_q)
    else $error("parity error not recorded");

  AST_SERR_PATH: assert property (
    bus_evt.addr_parity_err && cmd.system_error_enable
    && cmd.parity_response_enable && !serr_done
    ##1 cmd.system_error_enable |=> signaled_system_error_flag_q)
    else $error("system error flag not set after SERR");

  AST_SERR_GATE: assert property (
    !serr_req_q && !(cmd.system_error_enable
    && cmd.parity_response_enable) |=> !serr_req_q)
    else $error("SERR requested without both enables");

  AST_ABORTS: assert property (
    bus_evt.master_abort |=> master_abort_received_flag_q)
    else $error("master abort not recorded");

  AST_TABT_RX: assert property (
    bus_evt.target_abort_rcvd |=> target_abort_received_flag_q)
    else $error("received target abort not recorded");

  AST_TABT_TX: assert property (
    bus_evt.target_abort_sent ##1 !wr_hi
    |-> target_abort_signaled_flag_q [*2])
    else $error("signalled target abort lost");

  AST_DPAR_GATE: assert property (
    !master_data_parity_flag_q && !cmd.parity_response_enable
    |=> !master_data_parity_flag_q)
    else $error("data parity flag set without parity enable");

  AST_FIXED: assert property (
    cfg_rd && hit |=> cfg_rdata_q[10:9] == 2'h1
    && cfg_rdata_q[7:4] == 4'h1 && cfg_rdata_q[2:0] == 3'h0)
    else $error("hardwired status bits wrong");

  AST_INT_OUT: assert property (
    ##1 (int_n_q == !(int_stat_q && !$past(cmd.int_disable))))
    else $error("interrupt output disagrees with status");

  AST_READ: assert property (
    cfg_rd && hit |=> cfg_rdata_q == $past(status_word))
    else $error("read data does not match status");

  COV_CLEAR: cover property (wr_hi && cfg_wdata[15]
    && detected_parity_flag_q);
  COV_SET_CLEAR: cover property (wr_hi && cfg_wdata[13]
    && bus_evt.master_abort);
  COV_INT_MASKED: cover property (int_stat_q && int_n_q);
  COV_SERR: cover property (serr_req_q ##1 serr_done);

endmodule : pcsr_status

// ---- pcsr_bus_model.sv ----
`timescale 1ns/1ps
// ****
// Bus engine: drives SERR, then acks DELAY cycles after it first sees the request
// ****
module pcsr_bus_model #(
  parameter int DELAY = 2
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic serr_req_q,
  output logic serr_done
);
  int cnt_q;
  // Ack is a one-cycle pulse; a request held high past it is acked again every DELAY+1 cycles
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
    begin
      cnt_q <= 0;
      serr_done <= 1'b0;
    end
    else
    begin
      serr_done <= serr_req_q && cnt_q == DELAY && !serr_done;
      cnt_q <= (serr_req_q && cnt_q < DELAY) ? cnt_q + 1 : 0;
    end
endmodule : pcsr_bus_model

// ---- pcsr_status_bench.sv ----
`timescale 1ns/1ps
`include "pcsr_params.svh"
// ****
// Bench
// ****
module pcsr_status_bench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [1:0] cfg_be = 2'h0;
  logic [15:0] cfg_wdata = 16'h0000;
  pcsr_pkg::pcsr_evt_s bus_evt = '0;
  pcsr_pkg::pcsr_cmd_s cmd = '0;
  logic int_condition = 1'b0;
  logic serr_done;
  logic [15:0] cfg_rdata_q;
  logic serr_req_q;
  logic int_n_q;
  int fail_count = 0;
  int compares = 0;
  localparam logic [15:0] RV = `PCSR_STATUS_RESET;
  localparam logic [7:0] OFS = `PCSR_STATUS_OFFSET;
  always #10 sys_clk = ~sys_clk;
  pcsr_status dut (.sys_clk(sys_clk), .arst_n(arst_n), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .bus_evt(bus_evt), .cmd(cmd),
    .int_condition(int_condition), .serr_done(serr_done),
    .cfg_rdata_q(cfg_rdata_q), .serr_req_q(serr_req_q), .int_n_q(int_n_q));
  pcsr_bus_model #(.DELAY(3)) model (.sys_clk(sys_clk), .arst_n(arst_n),
    .serr_req_q(serr_req_q), .serr_done(serr_done));
  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [15:0] d);
    @(posedge sys_clk);
    cfg_wr <= wr;
    cfg_rd <= !wr;
    cfg_addr <= a;
    cfg_be <= 2'h3;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : access
  task automatic rd(input string what, input logic [15:0] e);
    access(1'b0, OFS, 16'h0000);
    chk(what, e, cfg_rdata_q);
  endtask : rd
  task automatic pulse(input pcsr_pkg::pcsr_evt_s v);
    @(posedge sys_clk);
    bus_evt <= v;
    @(posedge sys_clk);
    bus_evt <= '0;
  endtask : pulse
  task automatic t_fixed;
    rd("reset", RV);
    access(1'b1, OFS, 16'hFFFF);
    rd("fixed", RV);
    access(1'b0, 8'h04, 16'h0000);
    chk("unmapped", 16'h0000, cfg_rdata_q);
  endtask : t_fixed
  // Low-byte-only and other-address writes must not clear; set beats clear
  task automatic t_wr_ignore;
    pulse(7'h04);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= OFS;
    cfg_be <= 2'h1;
    cfg_wdata <= 16'hFFFF;
    @(posedge sys_clk);
    cfg_addr <= 8'h04;
    cfg_be <= 2'h3;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    rd("be_low", RV | 16'h2000);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= OFS;
    cfg_wdata <= 16'h2000;
    bus_evt <= 7'h04;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    bus_evt <= '0;
    rd("set_wins", RV | 16'h2000);
    access(1'b1, OFS, 16'h2000);
    rd("master_abort_received_flag_clr", RV);
  endtask : t_wr_ignore
  task automatic t_flag(input string w, input logic [6:0] v,
                        input logic [15:0] b);
    pulse(v);
    rd(w, RV | b);
    access(1'b1, OFS, ~b);
    rd(w, RV | b);
    access(1'b1, OFS, b);
    rd(w, RV);
  endtask : t_flag
  task automatic t_dpar_gate;
    pulse(7'h18);
    rd("dpar_no_en", RV);
    @(posedge sys_clk);
    cmd <= 3'b001;
    pulse(7'h10);
    rd("dpar_no_master", RV);
  endtask : t_dpar_gate
  task automatic t_serr;
    pulse(7'h40);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("serr_off", 16'h0000, {15'h0000, serr_req_q});
    rd("addr_par", RV | 16'h8000);
    access(1'b1, OFS, 16'h8000);
    @(posedge sys_clk);
    cmd <= 3'b011;
    pulse(7'h40);
    #1;
    chk("serr_on", 16'h0001, {15'h0000, serr_req_q});
    repeat (8) @(posedge sys_clk);
    rd("signaled_system_error_flag", RV | 16'hC000);
    access(1'b1, OFS, 16'hC000);
    rd("sys_clr", RV);
  endtask : t_serr
  task automatic t_int;
    @(posedge sys_clk);
    int_condition <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("int_on", 16'h0000, {15'h0000, int_n_q});
    rd("int_stat", RV | 16'h0008);
    @(posedge sys_clk);
    cmd <= 3'b100;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("int_off", 16'h0001, {15'h0000, int_n_q});
    access(1'b1, OFS, 16'h0008);
    rd("int_kept", RV | 16'h0008);
    @(posedge sys_clk);
    int_condition <= 1'b0;
    rd("int_gone", RV);
  endtask : t_int
  task automatic t_reset;
    pulse(7'h04);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd("global_reset_n", RV);
  endtask : t_reset
  initial
  begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_fixed;
    t_wr_ignore;
    t_flag("par_a", 7'h40, 16'h8000);
    t_flag("par_d", 7'h20, 16'h8000);
    t_flag("master_abort_received_flag", 7'h04, 16'h2000);
    t_flag("tabt_rx", 7'h02, 16'h1000);
    t_flag("tabt_tx", 7'h01, 16'h0800);
    t_dpar_gate;
    t_flag("dpar", 7'h18, 16'h0100);
    t_serr;
    t_int;
    t_reset;
    stop_test;
  end
  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    stop_test;
  end
endmodule : pcsr_status_bench
